/* shared/rng_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants and carrier types for the bus random number generator
// Assumes: single clock at 10 MHz, synchronous active-high reset
// Notes:   offsets are byte addresses inside a 4 KB peripheral window
//////////////////////////////////////////////////////////////////////////////
package rng_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // peripheral window base, for reference by software models
    localparam logic [31:0] WINDOW_BASE = 32'hFFFFA000;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_RANDOM_VALUE = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_GEN_CONTROL = 12'h004;

    // generator_control field positions
    localparam int BIT_REQUEST = 1;
    localparam int BIT_IRQ_ENABLE = 2;
    localparam int BIT_INTERRUPT_CLEAR = 3;
    localparam int BIT_NUMBER_READY = 5;
    localparam int BIT_IRQ_PENDING = 6;

    // reset values
    localparam logic [DATA_W-1:0] RESET_RANDOM_VALUE = 32'h00000000;
    localparam logic [DATA_W-1:0] RESET_GEN_CONTROL = 32'h00000000;

    // timing: one word must be done in fewer than this many bus cycles
    localparam int GEN_LIMIT_CYCLES = 256;
    // entropy samples folded into one word: two full passes of the shifter
    localparam int SAMPLES_PER_WORD = 2 * DATA_W;
    localparam int SAMPLE_CNT_W = 7;
    localparam logic [SAMPLE_CNT_W-1:0] LAST_SAMPLE =
        SAMPLE_CNT_W'(SAMPLES_PER_WORD - 1);

    // apb request carried as one bundle
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } apb_req_t;

    // apb answer
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic slverr;
    } apb_rsp_t;

    // generator sequencing
    typedef enum logic [1:0] {
        GEN_IDLE,
        GEN_COLLECT,
        GEN_DONE
    } gen_state_t;

endpackage

/* rtl/entropy_sync.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: bring the free-running entropy pin into the bus clock domain
// Assumes: entropy_i is asynchronous to mclk_i
// Notes:   three sync flops and an output flop; a change is taken once flops two and three agree
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns

module entropy_sync (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic entropy_i,
    output logic bit_o
);

    logic meta_q;
    logic meta_d;
    logic stage2_q;
    logic stage2_d;
    logic stage3_q;
    logic stage3_d;
    logic bit_q;
    logic bit_d;

    // first flop is read only by the second
    always_comb begin
        meta_d = entropy_i;
        stage2_d = meta_q;
        stage3_d = stage2_q;
        bit_d = bit_q;
        if (stage2_q == stage3_q) begin
            bit_d = stage3_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
            bit_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            stage2_q <= stage2_d;
            stage3_q <= stage3_d;
            bit_q <= bit_d;
        end
    end

    assign bit_o = bit_q;

endmodule

/* rtl/bus_random_number_generator.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: apb random number generator with ready flag and interrupt
// Assumes: zero-wait apb slave on mclk_i, entropy from an external source pin
// Notes:   a word takes 64 entropy samples plus sync latency, well under 256
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns

module bus_random_number_generator (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire rng_pkg::apb_req_t apb_req_i,
    output rng_pkg::apb_rsp_t apb_rsp_o,
    input wire logic entropy_i,
    output logic irq_o
);

    //////////////////////////////////////////////////////////////////////////
    // entropy source

    logic entropy_bit;

    entropy_sync u_entropy_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .entropy_i(entropy_i),
        .bit_o(entropy_bit)
    );

    //////////////////////////////////////////////////////////////////////////
    // bus decode

    logic wr_access;
    logic rd_setup;
    logic hit_value;
    logic hit_control;
    logic ctrl_write;
    logic [rng_pkg::DATA_W-1:0] wdata;

    always_comb begin
        hit_value = (apb_req_i.addr == rng_pkg::OFF_RANDOM_VALUE);
        hit_control = (apb_req_i.addr == rng_pkg::OFF_GEN_CONTROL);
        wr_access = apb_req_i.sel && apb_req_i.enable && apb_req_i.write;
        rd_setup = apb_req_i.sel && !apb_req_i.enable && !apb_req_i.write;
        ctrl_write = wr_access && hit_control;
        wdata = apb_req_i.wdata;
    end

    //////////////////////////////////////////////////////////////////////////
    // control register state

    logic request_q;
    logic request_d;
    logic irq_enable_q;
    logic irq_enable_d;
    logic irq_pending_q;
    logic irq_pending_d;
    logic request_fall;
    logic request_rise;
    logic ready_rise;

    always_comb begin
        request_d = request_q;
        irq_enable_d = irq_enable_q;
        irq_pending_d = irq_pending_q;
        if (ctrl_write) begin
            if (wdata[rng_pkg::BIT_INTERRUPT_CLEAR]) begin
                // clear only; request and enable are left alone
                irq_pending_d = 1'b0;
            end else begin
                request_d = wdata[rng_pkg::BIT_REQUEST];
                irq_enable_d = wdata[rng_pkg::BIT_IRQ_ENABLE];
            end
        end
        // a new completion in the clearing cycle is not lost
        if (ready_rise && irq_enable_q) begin
            irq_pending_d = 1'b1;
        end
        request_fall = request_q && !request_d;
        request_rise = !request_q && request_d;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            request_q <= 1'b0;
            irq_enable_q <= 1'b0;
            irq_pending_q <= 1'b0;
        end else begin
            request_q <= request_d;
            irq_enable_q <= irq_enable_d;
            irq_pending_q <= irq_pending_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // generator sequencing

    rng_pkg::gen_state_t state_q;
    rng_pkg::gen_state_t state_d;
    logic [rng_pkg::SAMPLE_CNT_W-1:0] sample_cnt_q;
    logic [rng_pkg::SAMPLE_CNT_W-1:0] sample_cnt_d;
    logic [rng_pkg::DATA_W-1:0] shift_q;
    logic [rng_pkg::DATA_W-1:0] shift_d;
    logic [rng_pkg::DATA_W-1:0] value_q;
    logic [rng_pkg::DATA_W-1:0] value_d;
    logic ready_q;
    logic ready_d;

    always_comb begin
        state_d = state_q;
        sample_cnt_d = sample_cnt_q;
        shift_d = shift_q;
        value_d = value_q;
        ready_d = ready_q;
        case (state_q)
            rng_pkg::GEN_IDLE: begin
                if (request_rise) begin
                    state_d = rng_pkg::GEN_COLLECT;
                    sample_cnt_d = '0;
                    shift_d = '0;
                end
            end
            rng_pkg::GEN_COLLECT: begin
                // the second pass folds each sample onto one from the first pass, evening out bias
                shift_d = {shift_q[rng_pkg::DATA_W-2:0],
                           entropy_bit ^ shift_q[rng_pkg::DATA_W-1]};
                sample_cnt_d = sample_cnt_q + 1'b1;
                if (sample_cnt_q == rng_pkg::LAST_SAMPLE) begin
                    state_d = rng_pkg::GEN_DONE;
                    value_d = {shift_q[rng_pkg::DATA_W-2:0],
                               entropy_bit ^ shift_q[rng_pkg::DATA_W-1]};
                    ready_d = 1'b1;
                end
            end
            rng_pkg::GEN_DONE: begin
                // ready holds until request is withdrawn; a rewrite of one is ignored
                ready_d = 1'b1;
            end
            default: begin
                state_d = rng_pkg::GEN_IDLE;
            end
        endcase
        if (request_fall) begin
            state_d = rng_pkg::GEN_IDLE;
            ready_d = 1'b0;
            value_d = rng_pkg::RESET_RANDOM_VALUE;
            shift_d = '0;
        end
        ready_rise = ready_d && !ready_q;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= rng_pkg::GEN_IDLE;
            sample_cnt_q <= '0;
            shift_q <= '0;
            value_q <= rng_pkg::RESET_RANDOM_VALUE;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sample_cnt_q <= sample_cnt_d;
            shift_q <= shift_d;
            value_q <= value_d;
            ready_q <= ready_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data and answer

    logic [rng_pkg::DATA_W-1:0] rdata_q;
    logic [rng_pkg::DATA_W-1:0] rdata_d;
    logic [rng_pkg::DATA_W-1:0] control_view;
    logic unmapped;

    always_comb begin
        control_view = rng_pkg::RESET_GEN_CONTROL;
        control_view[rng_pkg::BIT_REQUEST] = request_q;
        control_view[rng_pkg::BIT_IRQ_ENABLE] = irq_enable_q;
        control_view[rng_pkg::BIT_NUMBER_READY] = ready_q;
        control_view[rng_pkg::BIT_IRQ_PENDING] = irq_pending_q;
        rdata_d = rdata_q;
        if (rd_setup) begin
            if (hit_value) begin
                rdata_d = value_q;
            end else if (hit_control) begin
                rdata_d = control_view;
            end else begin
                rdata_d = '0;
            end
        end
        unmapped = !hit_value && !hit_control;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // zero-wait slave; writes to the data register are dropped quietly
    always_comb begin
        apb_rsp_o.rdata = rdata_q;
        apb_rsp_o.ready = 1'b1;
        apb_rsp_o.slverr = apb_req_i.sel && apb_req_i.enable && unmapped;
    end

    assign irq_o = irq_pending_q;

endmodule

/* tb/rng_properties.sv */
// Purpose: port properties of the random number generator
// Assumes: one clock, synchronous active-high reset
// Notes: helper mirrors request and enable as software wrote them
`timescale 1ns/1ns
module rng_properties (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire rng_pkg::apb_req_t apb_req_i,
    input wire rng_pkg::apb_rsp_t apb_rsp_o,
    input wire logic entropy_i,
    input wire logic irq_o
);
    logic req_q, req_d, old_q, en_q, en_d, acc, wr_c, rd_s, ctl, map;
    logic [7:0] cnt_q, cnt_d;
    assign acc = apb_req_i.sel & apb_req_i.enable;
    assign ctl = apb_req_i.addr == rng_pkg::OFF_GEN_CONTROL;
    assign map = ctl | (apb_req_i.addr == rng_pkg::OFF_RANDOM_VALUE);
    assign wr_c = acc & apb_req_i.write & ctl;
    assign rd_s = apb_req_i.sel & !apb_req_i.enable & !apb_req_i.write;
    always_comb begin
        req_d = req_q;
        en_d = en_q;
        cnt_d = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
        // a write with clear set must not touch the mirror
        if (wr_c && !apb_req_i.wdata[3]) begin
            req_d = apb_req_i.wdata[1];
            en_d = apb_req_i.wdata[2];
            if (!req_q) begin
                cnt_d = 8'h01;
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            req_q <= 1'b0;
            old_q <= 1'b0;
            en_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            req_q <= req_d;
            old_q <= req_q;
            en_q <= en_d;
            cnt_q <= cnt_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_unmapped_err: assert property (acc && !map |-> apb_rsp_o.slverr)
        else $error("unmapped access without slverr");
    a_mapped_ok: assert property (acc && map |-> !apb_rsp_o.slverr)
        else $error("mapped access with slverr");
    // a write access shows the last read word, so only read accesses count
    a_reserved_zero: assert property (acc && ctl && !apb_req_i.write
        |-> (apb_rsp_o.rdata & 32'hFFFFFF99) == 0)
        else $error("reserved control bits not zero");
    a_ready_early: assert property (rd_s && ctl && ((!req_q && !old_q) || (req_q && cnt_q <= 8'h40))
        |=> !apb_rsp_o.rdata[5])
        else $error("ready flag too early");
    a_ready_late: assert property (rd_s && ctl && req_q && cnt_q >= 8'h41
        |=> apb_rsp_o.rdata[5])
        else $error("ready flag late");
    a_data_zero: assert property (rd_s && !ctl && !req_q && !old_q |=> apb_rsp_o.rdata == 0)
        else $error("data not cleared");
    a_pending_view: assert property (rd_s && ctl |=> apb_rsp_o.rdata[6] == $past(irq_o))
        else $error("pending bit differs from irq");
    a_irq_cause: assert property ($rose(irq_o) |-> req_q && en_q && cnt_q == 8'h41)
        else $error("irq rose without cause");
    a_irq_clear: assert property (wr_c && apb_req_i.wdata[3] && irq_o |=> !irq_o)
        else $error("irq not cleared");
    a_irq_hold: assert property (irq_o && !(wr_c && apb_req_i.wdata[3]) |=> irq_o)
        else $error("irq dropped alone");
    c_irq: cover property ($rose(irq_o));
    c_err: cover property (acc && apb_rsp_o.slverr);
    c_ready: cover property (rd_s && ctl && req_q && cnt_q >= 8'h41);
endmodule
bind bus_random_number_generator rng_properties i_props (.mclk_i(mclk_i), .rst_i(rst_i),
    .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .entropy_i(entropy_i), .irq_o(irq_o));

/* tb/entropy_source.sv */
// Purpose: free-running noise pin
// Assumes: no relation to the bus clock
// Notes: irregular toggle spacing keeps sync edges varied
`timescale 1ns/1ns
module entropy_source (
    output logic bit_o
);
    logic [15:0] s;
    initial begin
        s = 16'hACE1;
        bit_o = 1'b0;
        forever begin
            #(13 + s[5:0]);
            s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
            bit_o = s[0];
        end
    end
endmodule

/* tb/tb.sv */
// Purpose: self-checking bench for the random number generator
// Assumes: zero-wait bus, reads checked by a monitor from a queue
// Notes: two words, both polled for ready, the first with irq enabled
`timescale 1ns/1ns
module tb;
    localparam logic [11:0] CTRL = rng_pkg::OFF_GEN_CONTROL;
    localparam logic [11:0] DATA = rng_pkg::OFF_RANDOM_VALUE;
    logic mclk_i, rst_i, ent, irq;
    rng_pkg::apb_req_t req;
    rng_pkg::apb_rsp_t rsp;
    logic [31:0] lfsr, seen, first;
    logic [32:0] expq[$], maskq[$];
    int fails, total_checks;
    bus_random_number_generator i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .apb_req_i(req),
        .apb_rsp_o(rsp), .entropy_i(ent), .irq_o(irq));
    entropy_source i_src (.bit_o(ent));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string what, input logic [32:0] e, input logic [32:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
        @(posedge mclk_i);
        req.enable <= 1'b1;
        do @(posedge mclk_i); while (rsp.ready !== 1'b1);
        seen = rsp.rdata;
        req <= '0;
        // one idle edge so the next setup is not a second drive in this step
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        expq.push_back(e);
        maskq.push_back(m);
        xfer(1'b0, a, 32'h00000000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk_i) begin
        if (req.sel && req.enable && !req.write && expq.size() > 0) begin
            if (maskq[0] != '0) begin
                check("read", expq[0] & maskq[0], {rsp.slverr, rsp.rdata} & maskq[0]);
            end
            void'(expq.pop_front());
            void'(maskq.pop_front());
        end
    end
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial begin
        #2000000;
        fails++;
        conclude();
    end
    initial begin
        int n;
        time t0;
        rst_i = 1'b1;
        req = '0;
        lfsr = 32'h00001650;
        fails = 0;
        total_checks = 0;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(DATA, 33'h0, '1);
        rd(CTRL, 33'h0, '1);
        rd(12'h008, 33'h100000000, '1);
        xfer(1'b1, DATA, lfsr);
        rd(DATA, 33'h0, '1);
        for (int g = 0; g < 2; g++) begin
            lfsr = nxt(lfsr);
            xfer(1'b1, CTRL, (lfsr & 32'hFFFFFF91) | (g == 0 ? 32'h6 : 32'h2));
            t0 = $time;
            rd(CTRL, 33'h0, 33'h20);
            n = 0;
            do begin
                rd(CTRL, 33'h0, 33'h0);
                n++;
            end while (seen[5] !== 1'b1 && n < 200);
            check("latency", 33'h1, {32'h0, ($time - t0) < rng_pkg::GEN_LIMIT_CYCLES * 100});
            rd(CTRL, g == 0 ? 33'h66 : 33'h22, '1);
            check("irq", {32'h0, g == 0}, {32'h0, irq});
            rd(DATA, 33'h0, 33'h0);
            if (g == 0) begin
                first = seen;
            end else begin
                check("fresh word", 33'h1, {32'h0, seen != first});
            end
            xfer(1'b1, CTRL, 32'h00000008);
            rd(CTRL, g == 0 ? 33'h26 : 33'h22, '1);
            check("irq", 33'h0, {32'h0, irq});
            xfer(1'b1, CTRL, 32'h00000000);
            rd(CTRL, 33'h0, '1);
            rd(DATA, 33'h0, '1);
        end
        repeat (4) @(posedge mclk_i);
        conclude();
    end
endmodule
